/* core/i2c_port_defs.vh */
// constants for the two-wire register port
`ifndef I2C_PORT_DEFS_VH
`define I2C_PORT_DEFS_VH
`define DEFAULT_SLAVE_ADDRESS     7'h2B
`define ADDR_OVERRIDE_NVM_INDEX   8'h04
`define REG_SPACE_BITS            8
`define STANDARD_RATE_KBPS        100
`define FAST_RATE_KBPS            400
`define SYS_CLK_MHZ               100
`endif

/* core/shadow_reg_mem.v */
// register space memory with registered read port
module shadow_reg_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          sys_clk_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem_reg [0:(1<<AW)-1];

    // write port and registered read port; no reset so it maps to ram
    always @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_reg[rd_addr_in];
    end
endmodule // shadow_reg_mem

/* core/i2c_slave_register_port.v */
// two-wire slave port into the 8-bit register space
`include "i2c_port_defs.vh"
module i2c_slave_register_port #(
    parameter AW = `REG_SPACE_BITS
) (
    input  wire          sys_clk_in,
    input  wire          srst_in,
    input  wire          scl_in,
    input  wire          sda_in,
    output reg           sda_out,
    output reg           sda_oe_out,
    input  wire          nvm_addr_valid_in,
    input  wire [6:0]    nvm_addr_in,
    input  wire          phase_start_in,
    input  wire [AW-1:0] core_rd_addr_in,
    output reg  [7:0]    core_rd_data_out,
    output reg           apply_strobe_out,
    output reg           busy_out
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_PTR  = 3'd2;
    localparam ST_WR   = 3'd3;
    localparam ST_RD   = 3'd4;
    localparam ST_MACK = 3'd5;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg  [1:0] scl_sync_reg;
    reg  [1:0] sda_sync_reg;
    reg        scl_d_reg;
    reg        sda_d_reg;
    reg  [6:0] own_addr_reg;

    // two flops per pin, then one delay stage for edge finding
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    wire scl_s   = scl_sync_reg[1];
    wire sda_s   = sda_sync_reg[1];
    wire scl_ris = scl_s & ~scl_d_reg;
    wire scl_fal = ~scl_s & scl_d_reg;
    // 10 ns sampling gives ample margin even at the fast rate
    wire start_c = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    wire stop_c  = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

    // address strap caught after reset release, never under it
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            own_addr_reg <= `DEFAULT_SLAVE_ADDRESS;
        end else if (nvm_addr_valid_in) begin
            own_addr_reg <= nvm_addr_in;
        end
    end

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    reg  [2:0]    state_reg;
    reg  [7:0]    shift_reg;
    reg  [3:0]    bit_cnt_reg;
    reg           ack_phase_reg;
    reg  [AW-1:0] ptr_reg;
    reg           wr_en_reg;
    reg  [AW-1:0] wr_addr_reg;
    reg  [7:0]    wr_data_reg;
    reg           pending_reg;
    wire [7:0]    rd_data;
    wire [7:0]    core_data;
    // pointer step at full width, so the increment wraps cleanly at the top
    wire [AW-1:0] ptr_step = {{(AW-1){1'b0}}, 1'b1};

    shadow_reg_mem #(.AW(AW), .DW(8)) u_mem ( // all register classes share it
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (wr_en_reg),
        .wr_addr_in  (wr_addr_reg),
        .wr_data_in  (wr_data_reg),
        .rd_addr_in  (ptr_reg),
        .rd_data_out (rd_data)
    );

    // second read port for the core side: a mirror copy
    shadow_reg_mem #(.AW(AW), .DW(8)) u_core_mem (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (wr_en_reg),
        .wr_addr_in  (wr_addr_reg),
        .wr_data_in  (wr_data_reg),
        .rd_addr_in  (core_rd_addr_in),
        .rd_data_out (core_data)
    );

    // bus protocol; bits sampled on rising scl, sda changed on falling
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_reg     <= ST_IDLE;
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 4'd0;
            ack_phase_reg <= 1'b0;
            ptr_reg       <= {AW{1'b0}};
            wr_en_reg     <= 1'b0;
            wr_addr_reg   <= {AW{1'b0}};
            wr_data_reg   <= 8'h00;
            sda_out       <= 1'b0;
            sda_oe_out    <= 1'b0;
        end else begin
            wr_en_reg <= 1'b0;
            if (stop_c) begin
                state_reg  <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end else if (start_c) begin
                // repeated start also lands here
                state_reg     <= ST_ADDR;
                bit_cnt_reg   <= 4'd0;
                ack_phase_reg <= 1'b0;
                sda_oe_out    <= 1'b0;
            end else if (scl_ris && !ack_phase_reg && state_reg != ST_IDLE
                         && state_reg != ST_RD) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end else if (scl_ris && state_reg == ST_MACK) begin
                // master ack continues, nack ends the stream
                if (sda_s) begin
                    state_reg     <= ST_IDLE;
                    ack_phase_reg <= 1'b0;
                end else begin
                    // keep the ack phase so the next fall loads a fresh byte
                    state_reg     <= ST_RD;
                    ack_phase_reg <= 1'b1;
                end
                bit_cnt_reg   <= 4'd0;
            end else if (scl_fal) begin
                if (ack_phase_reg) begin
                    // end of an ack slot, ours or the master's
                    ack_phase_reg <= 1'b0;
                    bit_cnt_reg   <= 4'd0;
                    if (state_reg == ST_RD) begin
                        sda_oe_out <= ~rd_data[7]; // first read bit
                        sda_out    <= 1'b0;
                        shift_reg  <= {rd_data[6:0], 1'b1};
                        ptr_reg    <= ptr_reg + ptr_step;
                        bit_cnt_reg <= 4'd1;
                    end else begin
                        sda_oe_out <= 1'b0;
                    end
                end else if (state_reg == ST_RD) begin
                    if (bit_cnt_reg == 4'd8) begin
                        sda_oe_out <= 1'b0; // release for master ack
                        state_reg  <= ST_MACK;
                        ack_phase_reg <= 1'b1;
                    end else begin
                        sda_oe_out  <= ~shift_reg[7];
                        shift_reg   <= {shift_reg[6:0], 1'b1};
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end
                end else if (bit_cnt_reg == 4'd8 && state_reg != ST_IDLE
                             && state_reg != ST_MACK) begin
                    ack_phase_reg <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            if (shift_reg[7:1] == own_addr_reg) begin
                                sda_oe_out <= 1'b1;
                                state_reg  <= shift_reg[0] ? ST_RD : ST_PTR;
                            end else begin
                                state_reg  <= ST_IDLE;
                                ack_phase_reg <= 1'b0;
                            end
                        end
                        ST_PTR: begin
                            sda_oe_out <= 1'b1;
                            ptr_reg    <= shift_reg[AW-1:0];
                            state_reg  <= ST_WR;
                        end
                        ST_WR: begin
                            sda_oe_out  <= 1'b1;
                            wr_en_reg   <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= shift_reg;
                            ptr_reg     <= ptr_reg + ptr_step;
                        end
                        default: begin
                            sda_oe_out <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // apply writes at the next processing phase
    // ----------------------------------------------------------------
    // host writes are taken any time but surfaced only on the phase
    // strobe, so core logic never sees half a burst mid-phase
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            pending_reg      <= 1'b0;
            apply_strobe_out <= 1'b0;
            busy_out         <= 1'b0;
            core_rd_data_out <= 8'h00;
        end else begin
            apply_strobe_out <= phase_start_in & (pending_reg | wr_en_reg);
            if (wr_en_reg) begin
                pending_reg <= 1'b1; // set wins over clear
            end else if (phase_start_in) begin
                pending_reg <= 1'b0;
            end
            busy_out <= (state_reg != ST_IDLE);
            if (phase_start_in) begin
                core_rd_data_out <= core_data;
            end
        end
    end
endmodule // i2c_slave_register_port

/* tb/i2c_port_chk.sv */
// assertion checker for the two-wire register port
module i2c_port_chk #(
    parameter AW = 8
) (
    input wire logic          sys_clk_in, srst_in, scl_in, sda_in, sda_out, sda_oe_out,
    input wire logic          nvm_addr_valid_in, phase_start_in, apply_strobe_out, busy_out,
    input wire logic [6:0]    nvm_addr_in,
    input wire logic [AW-1:0] core_rd_addr_in,
    input wire logic [7:0]    core_rd_data_out
);
    timeunit 1ns;
    timeprecision 10ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    // ------------------------------------------------------------
    // pin and core-side relations
    // ------------------------------------------------------------
    AST_OD_VALUE: assert property (sda_out == 1'b0) else $error("sda value not low");
    AST_RESET_QUIET: assert property (disable iff (1'b0) srst_in |=> !sda_oe_out && !busy_out)
        else $error("outputs active after reset");
    AST_APPLY_CAUSE: assert property (apply_strobe_out |-> $past(phase_start_in) || $past(phase_start_in, 2))
        else $error("apply without phase start");
    AST_RD_HOLD: assert property (!phase_start_in |=> $stable(core_rd_data_out))
        else $error("core data moved outside phase");
    AST_OE_SCL_LOW: assert property ($rose(sda_oe_out) |-> !scl_in) else $error("drive began with scl high");
    AST_OE_BUSY: assert property (sda_oe_out |-> busy_out) else $error("drive while not addressed");
    AST_ACK_STANDS: assert property ($rose(sda_oe_out) |-> sda_oe_out [*4]) else $error("drive too short");
    AST_OE_MOVE: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 3))
        else $error("sda moved during scl high");
    // main scenarios reached
    COV_ACK: cover property ($rose(sda_oe_out));
    COV_APPLY: cover property (apply_strobe_out);
    COV_END: cover property ($fell(busy_out));
endmodule // i2c_port_chk

bind i2c_slave_register_port i2c_port_chk #(.AW(AW)) u_chk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .nvm_addr_valid_in(nvm_addr_valid_in), .phase_start_in(phase_start_in), .apply_strobe_out(apply_strobe_out),
    .busy_out(busy_out), .nvm_addr_in(nvm_addr_in), .core_rd_addr_in(core_rd_addr_in),
    .core_rd_data_out(core_rd_data_out));

/* tb/i2c_host_model.sv */
// bus master model: drives scl, pulls sda low, samples the wire
module i2c_host_model (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    timeunit 1ns;
    timeprecision 10ps;
    // scl stands high between frames, never free-running
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one bit: set data while scl low, sample at mid high
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = !b;
        #31.25 scl_out = 1'b1;
        #31.25 r = sda_in;
        #31.25 scl_out = 1'b0;
        #31.25;
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        sda_low_out = 1'b0;
        #31.25 scl_out = 1'b1;
        #31.25 sda_low_out = 1'b1;
        #31.25 scl_out = 1'b0;
        #31.25;
    endtask
    // stop: sda rises while scl high
    task automatic stop();
        sda_low_out = 1'b1;
        #31.25 scl_out = 1'b1;
        #31.25 sda_low_out = 1'b0;
        #62.5;
    endtask
    // byte msb first, then ninth bit; ack reports a low ninth bit
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(nine, ack);
        ack = !ack;
    endtask
endmodule // i2c_host_model

/* tb/i2c_slave_register_port_test.sv */
// self-checking bench for the two-wire register port
module i2c_slave_register_port_test;
    timeunit 1ns;
    timeprecision 10ps;
    logic       sys_clk_in = 0, srst_in = 1, nvm_addr_valid_in = 0, phase_start_in = 0, a;
    logic [6:0] nvm_addr_in = 7'h00, slave_address = 7'h2B;
    logic [7:0] core_rd_addr_in = 8'h00, q;
    wire        scl, sda_low, sda_out, sda_oe_out, apply_strobe_out, busy_out;
    wire  [7:0] core_rd_data_out;
    wire        sda = !(sda_low | sda_oe_out); // pulled-up open-drain wire
    int         failures = 0, cmp_count = 0, cycles = 0, mem[256];
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
    i2c_host_model u_host (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    i2c_slave_register_port u_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .nvm_addr_valid_in(nvm_addr_valid_in),
        .nvm_addr_in(nvm_addr_in), .phase_start_in(phase_start_in), .core_rd_addr_in(core_rd_addr_in),
        .core_rd_data_out(core_rd_data_out), .apply_strobe_out(apply_strobe_out), .busy_out(busy_out));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // write n random bytes from pointer p; the model memory follows
    task automatic wr(input logic [6:0] sa, input int p, input int n, input logic exp);
        u_host.start();
        u_host.xfer({sa, 1'b0}, 1'b1, q, a);
        `CHK("address ack", exp, a)
        if (a) begin
            u_host.xfer(8'(p), 1'b1, q, a);
            `CHK("pointer ack", 1'b1, a)
            for (int i = 0; i < n; i++) begin
                mem[(p + i) % 256] = $urandom % 256;
                u_host.xfer(8'(mem[(p + i) % 256]), 1'b1, q, a);
                `CHK("data ack", 1'b1, a)
            end
        end
        u_host.stop();
    endtask
    // pointer write, repeated start, n reads, last one refused
    task automatic rd(input int p, input int n);
        u_host.start();
        u_host.xfer({slave_address, 1'b0}, 1'b1, q, a);
        u_host.xfer(8'(p), 1'b1, q, a);
        u_host.start();
        u_host.xfer({slave_address, 1'b1}, 1'b1, q, a);
        `CHK("read ack", 1'b1, a)
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'hFF, i == n - 1, q, a);
            `CHK("read byte", 8'(mem[(p + i) % 256]), q)
        end
        u_host.stop();
    endtask
    // processing phase pulse, then check apply and core read
    task automatic phase(input int p, input logic ap);
        logic seen;
        @(negedge sys_clk_in);
        core_rd_addr_in = 8'(p);
        repeat (4) @(negedge sys_clk_in);
        phase_start_in = 1'b1;
        @(negedge sys_clk_in);
        phase_start_in = 1'b0;
        seen = apply_strobe_out;
        @(negedge sys_clk_in);
        `CHK("apply", ap, seen | apply_strobe_out)
        `CHK("core data", 8'(mem[p]), core_rd_data_out)
    endtask
    // runaway guard, about seven times the expected length
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(65));
        repeat (16) @(negedge sys_clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        wr(7'h2C, 8'h10, 1, 1'b0);
        wr(slave_address, 8'hFE, 3, 1'b1);
        phase(8'hFF, 1'b1);
        phase(8'h00, 1'b0);
        rd(8'hFE, 3);
        @(negedge sys_clk_in);
        nvm_addr_in = 7'h40 | 7'($urandom % 32);
        nvm_addr_valid_in = 1'b1;
        wr(7'h2B, 8'h20, 1, 1'b0);
        slave_address = nvm_addr_in;
        wr(slave_address, 8'h20, 2, 1'b1);
        rd(8'h20, 2);
        complete_run();
    end
endmodule // i2c_slave_register_port_test
